//--- fcs_top.sv
// flash command sequencer: control register, bank map, sequence decoder, busy toggle
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module fcs_top #(
	parameter int ERASE_CYC = fcs_pkg::FCS_ERASE_CYC,
	parameter logic [7:0] VENDOR_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] MACRO_CODE = 8'h3C // arbitrary value
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// operating mode levels
	input wire logic serialMode,
	input wire logic parallelMode,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// processor bus toward flash
	input fcs_pkg::fcs_cpu_req_s cpuReq,
	output logic [7:0] cpuRdata,
	output logic cpuRdValid,
	// flash array side
	output fcs_pkg::fcs_arr_cmd_s arrCmd,
	input wire logic [7:0] arrRdata,
	// status levels
	output logic busy,
	output logic idMode
);
	import fcs_pkg::*;

	localparam logic [FCS_CNT_W-1:0] PROG_CNT = FCS_CNT_W'(FCS_PROG_CYC - 1);
	localparam logic [FCS_CNT_W-1:0] ERASE_CNT = FCS_CNT_W'(ERASE_CYC - 1);

	fcs_state_s s_q;
	fcs_state_s s_d;

	// ****************************************
	// address map
	// ****************************************
	logic mapValid;
	logic mapBoot;
	logic [15:0] mapLoc;

	always_comb begin
		mapValid = 1'b0;
		mapBoot = 1'b0;
		mapLoc = cpuReq.addr;
		if (!serialMode) begin
			mapValid = (cpuReq.addr >= FCS_FLASH_LO);
		end else if (cpuReq.addr >= FCS_BANK_BASE) begin
			if (s_q.bankSel) begin
				mapValid = 1'b1;
			end else if (cpuReq.addr >= FCS_LOWER_BANK_LO) begin
				mapValid = 1'b1;
				mapLoc = cpuReq.addr - FCS_BANK_BASE;
			end
		end else if (cpuReq.addr >= FCS_BOOT_LO) begin
			mapBoot = 1'b1;
		end
	end

	// ****************************************
	// write decode helpers
	// ****************************************
	logic enabled;
	logic isA;
	logic isB;
	logic isSecAddr;

	assign enabled = (s_q.unlock == FCS_UNLOCK_ON);
	assign isA = (cpuReq.addr[11:0] == FCS_CYC_A);
	assign isB = (cpuReq.addr[11:0] == FCS_CYC_B);
	assign isSecAddr = (cpuReq.addr == FCS_SEC_ADDR);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.arr.start = 1'b0;
		s_d.arr.rd = 1'b0;
		s_d.cpuRdValid = 1'b0;
		s_d.arrPend = 1'b0;

		// register port
		if (regWr && regAddr == FCS_REG_CTRL) begin
			s_d.unlock = regWdata[FCS_UNLOCK_MSB:FCS_UNLOCK_LSB];
			s_d.bankSel = regWdata[FCS_BANK_BIT];
		end
		if (regRd) begin
			s_d.regRdata = '0;
			if (regAddr == FCS_REG_CTRL) begin
				s_d.regRdata[FCS_UNLOCK_MSB:FCS_UNLOCK_LSB] = s_q.unlock;
				s_d.regRdata[FCS_BANK_BIT] = s_q.bankSel;
			end else if (regAddr == FCS_REG_STAT) begin
				s_d.regRdata[FCS_ST_BUSY] = (s_q.fsm == FCS_BUSY);
				s_d.regRdata[FCS_ST_ID] = s_q.idMode;
				s_d.regRdata[FCS_ST_SECURE] = s_q.secure;
			end
		end

		// sequence decoder
		if (cpuReq.wr && s_q.fsm != FCS_BUSY) begin
			s_d.fsm = FCS_IDLE;
			if (enabled) begin
				unique case (s_q.fsm)
					FCS_IDLE: begin
						if (isA && cpuReq.wdata == FCS_D_AA) begin
							s_d.fsm = FCS_C1;
						end else if (cpuReq.wdata == FCS_D_IDOUT) begin
							s_d.idMode = 1'b0;
						end
					end
					FCS_C1: begin
						if (isB && cpuReq.wdata == FCS_D_55) begin
							s_d.fsm = FCS_C2;
						end
					end
					FCS_C2: begin
						if (isA) begin
							unique case (cpuReq.wdata)
								FCS_D_PROG: s_d.fsm = FCS_PROG;
								FCS_D_ERASE: s_d.fsm = FCS_E3;
								FCS_D_SECP: s_d.fsm = FCS_SEC;
								FCS_D_IDIN: s_d.idMode = 1'b1;
								FCS_D_IDOUT: s_d.idMode = 1'b0;
								default: s_d.fsm = FCS_IDLE;
							endcase
						end
					end
					FCS_PROG: begin
						if (mapValid) begin
							s_d.fsm = FCS_BUSY;
							s_d.opKind = FCS_OP_PROG;
							s_d.cnt = PROG_CNT;
						end
					end
					FCS_E3: begin
						if (isA && cpuReq.wdata == FCS_D_AA) begin
							s_d.fsm = FCS_E4;
						end
					end
					FCS_E4: begin
						if (isB && cpuReq.wdata == FCS_D_55) begin
							s_d.fsm = FCS_E5;
						end
					end
					FCS_E5: begin
						if (cpuReq.wdata == FCS_D_SECT && mapValid && !parallelMode) begin
							s_d.fsm = FCS_BUSY;
							s_d.opKind = FCS_OP_SECT;
							s_d.cnt = ERASE_CNT;
						end else if (isA && cpuReq.wdata == FCS_D_CHIP) begin
							s_d.fsm = FCS_BUSY;
							s_d.opKind = FCS_OP_CHIP;
							s_d.cnt = ERASE_CNT;
						end
					end
					FCS_SEC: begin
						if (isSecAddr && cpuReq.wdata == FCS_D_SECV) begin
							s_d.fsm = FCS_BUSY;
							s_d.opKind = FCS_OP_SECP;
							s_d.cnt = PROG_CNT;
						end
					end
					FCS_BUSY: s_d.fsm = FCS_BUSY;
				endcase
			end
			if (s_d.fsm == FCS_BUSY) begin
				s_d.toggle = 1'b1;
				s_d.arr.start = 1'b1;
				s_d.arr.kind = s_d.opKind;
				s_d.arr.boot = 1'b0;
				s_d.arr.addr = (s_d.opKind == FCS_OP_SECP) ? cpuReq.addr : mapLoc;
				s_d.arr.wdata = cpuReq.wdata;
			end
		end else if (s_q.fsm == FCS_BUSY) begin
			// writes while busy are refused
			if (s_q.cnt == '0) begin
				s_d.fsm = FCS_IDLE;
				if (s_q.opKind == FCS_OP_SECP) begin
					s_d.secure = 1'b1;
				end else if (s_q.opKind == FCS_OP_CHIP) begin
					s_d.secure = 1'b0;
				end
			end else begin
				s_d.cnt = s_q.cnt - FCS_CNT_W'(1);
			end
		end

		// read path
		if (s_q.arrPend) begin
			s_d.cpuRdata = arrRdata;
			s_d.cpuRdValid = 1'b1;
		end
		if (cpuReq.rd) begin
			if (s_q.fsm == FCS_BUSY) begin
				s_d.cpuRdata = '0;
				s_d.cpuRdata[FCS_TOGGLE_BIT] = s_q.toggle;
				s_d.toggle = ~s_q.toggle;
				s_d.cpuRdValid = 1'b1;
			end else if (s_q.idMode && (cpuReq.addr == FCS_ID_VENDOR ||
					cpuReq.addr == FCS_ID_MACRO || cpuReq.addr == FCS_ID_SIZE ||
					cpuReq.addr == FCS_SEC_ADDR)) begin
				s_d.cpuRdValid = 1'b1;
				if (cpuReq.addr == FCS_ID_VENDOR) begin
					s_d.cpuRdata = VENDOR_CODE;
				end else if (cpuReq.addr == FCS_ID_MACRO) begin
					s_d.cpuRdata = MACRO_CODE;
				end else if (cpuReq.addr == FCS_ID_SIZE) begin
					s_d.cpuRdata = FCS_SIZE_CODE;
				end else begin
					s_d.cpuRdata = s_q.secure ? FCS_SEC_ON : FCS_SEC_OFF;
				end
			end else if (mapValid || mapBoot) begin
				s_d.arr.rd = 1'b1;
				s_d.arr.boot = mapBoot;
				s_d.arr.addr = mapLoc;
			end else begin
				s_d.cpuRdata = '0;
				s_d.cpuRdValid = 1'b1;
			end
		end
		if (s_q.arr.rd) begin
			s_d.arrPend = 1'b1;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{
				fsm: FCS_IDLE,
				unlock: FCS_UNLOCK_RST,
				bankSel: 1'b0,
				idMode: 1'b0,
				secure: 1'b0,
				opKind: FCS_OP_PROG,
				cnt: '0,
				toggle: 1'b1,
				arrPend: 1'b0,
				arr: '0,
				cpuRdata: '0,
				cpuRdValid: 1'b0,
				regRdata: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regRdata = s_q.regRdata;
	assign cpuRdata = s_q.cpuRdata;
	assign cpuRdValid = s_q.cpuRdValid;
	assign arrCmd = s_q.arr;
	// one-hot: the busy state bit itself
	assign busy = |(s_q.fsm & FCS_BUSY);
	assign idMode = s_q.idMode;

endmodule

//--- fcs_pkg.sv
// constants, types and state layout of the flash command sequencer
package fcs_pkg;

	// ****************************************
	// register port
	// ****************************************
	localparam logic [3:0] FCS_REG_CTRL = 4'h0;
	localparam logic [3:0] FCS_REG_STAT = 4'h1;
	localparam logic [3:0] FCS_UNLOCK_ON = 4'h3;
	localparam logic [3:0] FCS_UNLOCK_RST = 4'hC;
	localparam int FCS_UNLOCK_MSB = 7;
	localparam int FCS_UNLOCK_LSB = 4;
	localparam int FCS_BANK_BIT = 3;
	localparam int FCS_ST_BUSY = 0;
	localparam int FCS_ST_ID = 1;
	localparam int FCS_ST_SECURE = 2;

	// ****************************************
	// address map
	// ****************************************
	localparam logic [15:0] FCS_FLASH_LO = 16'h1000;
	localparam logic [15:0] FCS_BOOT_LO = 16'h7800;
	localparam logic [15:0] FCS_BANK_BASE = 16'h8000;
	localparam logic [15:0] FCS_LOWER_BANK_LO = 16'h9000;
	localparam logic [15:0] FCS_ID_VENDOR = 16'hF000;
	localparam logic [15:0] FCS_ID_MACRO = 16'hF001;
	localparam logic [15:0] FCS_ID_SIZE = 16'hF002;
	localparam logic [15:0] FCS_SEC_ADDR = 16'hFF7F;
	localparam logic [11:0] FCS_CYC_A = 12'h555;
	localparam logic [11:0] FCS_CYC_B = 12'hAAA;

	// ****************************************
	// command data
	// ****************************************
	localparam logic [7:0] FCS_D_AA = 8'hAA;
	localparam logic [7:0] FCS_D_55 = 8'h55;
	localparam logic [7:0] FCS_D_PROG = 8'hA0;
	localparam logic [7:0] FCS_D_ERASE = 8'h80;
	localparam logic [7:0] FCS_D_SECT = 8'h30;
	localparam logic [7:0] FCS_D_CHIP = 8'h10;
	localparam logic [7:0] FCS_D_IDIN = 8'h90;
	localparam logic [7:0] FCS_D_IDOUT = 8'hF0;
	localparam logic [7:0] FCS_D_SECP = 8'hA5;
	localparam logic [7:0] FCS_D_SECV = 8'h00;
	localparam logic [7:0] FCS_SEC_OFF = 8'hFF;
	localparam logic [7:0] FCS_SEC_ON = 8'h00;
	localparam logic [7:0] FCS_SIZE_CODE = 8'h0E;
	localparam int FCS_TOGGLE_BIT = 6;

	// ****************************************
	// timing
	// ****************************************
	localparam int FCS_CLK_MHZ = 40;
	localparam int FCS_PROG_US = 40;
	localparam int FCS_ERASE_MS = 30;
	localparam int FCS_PROG_CYC = FCS_PROG_US * FCS_CLK_MHZ;
	localparam int FCS_ERASE_CYC = FCS_ERASE_MS * 1000 * FCS_CLK_MHZ;
	localparam int FCS_CNT_W = 21;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [8:0] {
		FCS_IDLE = 9'b000000001,
		FCS_C1 = 9'b000000010,
		FCS_C2 = 9'b000000100,
		FCS_PROG = 9'b000001000,
		FCS_E3 = 9'b000010000,
		FCS_E4 = 9'b000100000,
		FCS_E5 = 9'b001000000,
		FCS_SEC = 9'b010000000,
		FCS_BUSY = 9'b100000000
	} fcs_state_e;

	typedef enum logic [1:0] {
		FCS_OP_PROG = 2'h0,
		FCS_OP_SECT = 2'h1,
		FCS_OP_CHIP = 2'h2,
		FCS_OP_SECP = 2'h3
	} fcs_op_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fcs_cpu_req_s;

	typedef struct packed {
		logic start;
		fcs_op_e kind;
		logic rd;
		logic boot;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fcs_arr_cmd_s;

	typedef struct packed {
		fcs_state_e fsm;
		logic [3:0] unlock;
		logic bankSel;
		logic idMode;
		logic secure;
		fcs_op_e opKind;
		logic [FCS_CNT_W-1:0] cnt;
		logic toggle;
		logic arrPend;
		fcs_arr_cmd_s arr;
		logic [7:0] cpuRdata;
		logic cpuRdValid;
		logic [7:0] regRdata;
	} fcs_state_s;

endpackage

//--- fcs_top_assertions.sv
// port checker for the flash command sequencer
`timescale 1ns/100ps
module fcs_top_chk #(
	parameter int ERASE_CYC = fcs_pkg::FCS_ERASE_CYC,
	parameter logic [7:0] VENDOR_CODE = 8'h5A
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// watched ports
	input wire logic serialMode,
	input wire logic regRd,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regRdata,
	input fcs_pkg::fcs_cpu_req_s cpuReq,
	input wire logic [7:0] cpuRdata,
	input wire logic cpuRdValid,
	input fcs_pkg::fcs_arr_cmd_s arrCmd,
	input wire logic [7:0] arrRdata,
	input wire logic busy,
	input wire logic idMode
);
	import fcs_pkg::*;
	logic [21:0] run_q;
	// ****************************************
	// busy run length
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 22'h0;
		end else begin
			run_q <= busy ? run_q + 22'h1 : 22'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ****************************************
	// properties
	// ****************************************
	chk_start_busy: assert property (
		$rose(busy) == arrCmd.start) else $error("start and busy rise differ");
	chk_no_fetch: assert property (
		busy && $past(busy) |-> !arrCmd.rd) else $error("array read while busy");
	chk_busy_read: assert property (
		busy && cpuReq.rd |=> cpuRdValid && (cpuRdata & 8'hBF) == 8'h00)
		else $error("bad busy answer");
	chk_arr_pass: assert property (
		arrCmd.rd |-> ##2 cpuRdValid && cpuRdata == $past(arrRdata))
		else $error("array data not passed");
	chk_direct_map: assert property (
		!serialMode && !busy && !idMode && cpuReq.rd && cpuReq.addr >= FCS_FLASH_LO
		|=> arrCmd.rd && !arrCmd.boot && arrCmd.addr == $past(cpuReq.addr))
		else $error("normal mode address changed");
	chk_boot_map: assert property (
		serialMode && !busy && cpuReq.rd && cpuReq.addr[15:11] == 5'h0F
		|=> arrCmd.rd && arrCmd.boot) else $error("boot area missed");
	chk_vendor_id: assert property (
		idMode && !busy && cpuReq.rd && cpuReq.addr == FCS_ID_VENDOR
		|=> cpuRdValid && cpuRdata == VENDOR_CODE) else $error("vendor code wrong");
	chk_busy_len: assert property (
		run_q <= FCS_PROG_CYC + 1 || run_q <= ERASE_CYC + 1) else $error("busy too long");
	cover property (arrCmd.start && arrCmd.kind == FCS_OP_PROG);
	cover property (arrCmd.start && arrCmd.kind == FCS_OP_CHIP);
	cover property (arrCmd.start && arrCmd.kind == FCS_OP_SECP);
endmodule
bind fcs_top fcs_top_chk #(.ERASE_CYC(ERASE_CYC), .VENDOR_CODE(VENDOR_CODE)) chk (
	.clk(clk), .rstn(rstn), .serialMode(serialMode), .regRd(regRd),
	.regAddr(regAddr), .regRdata(regRdata), .cpuReq(cpuReq), .cpuRdata(cpuRdata),
	.cpuRdValid(cpuRdValid), .arrCmd(arrCmd), .arrRdata(arrRdata), .busy(busy),
	.idMode(idMode));

//--- fcs_flash_model.sv
// flash array model answering a read one cycle after it
`timescale 1ns/100ps
module fcs_flash_model (
	// clock
	input wire logic clk,
	// array side
	input fcs_pkg::fcs_arr_cmd_s arrCmd,
	output logic [7:0] arrRdata
);
	import fcs_pkg::*;
	logic erased_q = 1'b0;
	initial arrRdata = 8'hFF;
	always @(posedge clk) begin
		if (arrCmd.start && arrCmd.kind == FCS_OP_CHIP)
			erased_q <= 1'b1;
		// data only in the answer cycle, otherwise it keeps changing
		if (arrCmd.rd)
			arrRdata <= erased_q ? 8'hFF : arrCmd.boot ? 8'hB0 : arrCmd.addr[15:8] ^ arrCmd.addr[7:0];
		else
			arrRdata <= ~arrRdata;
	end
endmodule

//--- tb_fcs_top.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED %0t: %h vs %h", $time, a, b); end end
module tb_fcs_top;
	import fcs_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic serialMode = 1'b0;
	logic parallelMode = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	fcs_cpu_req_s cpuReq = '0;
	logic [7:0] regRdata, cpuRdata, arrRdata;
	logic cpuRdValid, busy, idMode;
	fcs_arr_cmd_s arrCmd;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	always #12.5 clk = ~clk;
	fcs_top #(.ERASE_CYC(50)) DUT (.clk(clk), .rstn(rstn), .serialMode(serialMode),
		.parallelMode(parallelMode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .cpuReq(cpuReq), .cpuRdata(cpuRdata),
		.cpuRdValid(cpuRdValid), .arrCmd(arrCmd), .arrRdata(arrRdata), .busy(busy),
		.idMode(idMode));
	fcs_flash_model arr (.clk(clk), .arrCmd(arrCmd), .arrRdata(arrRdata));
	// ****************************************
	// access tasks
	// ****************************************
	task automatic rw(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rr(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CMP(regRdata, e)
	endtask
	task automatic cw(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		cpuReq.addr <= a;
		cpuReq.wdata <= d;
		cpuReq.wr <= 1'b1;
		@(posedge clk);
		cpuReq.wr <= 1'b0;
		#1;
	endtask
	task automatic cr(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		cpuReq.addr <= a;
		cpuReq.rd <= 1'b1;
		@(posedge clk);
		cpuReq.rd <= 1'b0;
		n = 0;
		#1;
		while (cpuRdValid !== 1'b1 && n < 9) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CMP(cpuRdValid, 1'b1)
		`CMP(cpuRdata, e)
	endtask
	// unlock prefix with varied upper address bits
	task automatic cmd(input logic [7:0] d);
		cw(16'hF555, FCS_D_AA);
		cw(16'h3AAA, FCS_D_55);
		cw(16'h0555, d);
	endtask
	task automatic ers(input logic [15:0] a, input logic [7:0] d);
		cmd(FCS_D_ERASE);
		cw(16'h1555, FCS_D_AA);
		cw(16'h2AAA, FCS_D_55);
		cw(a, d);
	endtask
	task automatic idle(input int lim);
		n = 0;
		while (busy === 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CMP(n <= lim, 1'b1)
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			close_out();
		end
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rr(4'h0, 8'hC0);
		rr(4'h7, 8'h00);
		cmd(FCS_D_PROG);
		cw(16'h2345, 8'h77);
		`CMP(busy, 1'b0)
		$display("test locked done");
		rw(4'h0, 8'h30);
		rr(4'h0, 8'h30);
		cmd(FCS_D_PROG);
		cw(16'h2345, 8'h77);
		`CMP(busy, 1'b1)
		cr(16'h2345, 8'h40);
		cr(16'h2345, 8'h00);
		cmd(FCS_D_IDIN);
		idle(1601);
		`CMP(idMode, 1'b0)
		$display("test program done");
		cmd(FCS_D_IDIN);
		`CMP(idMode, 1'b1)
		cr(FCS_ID_VENDOR, 8'h5A);
		cr(FCS_ID_MACRO, 8'h3C);
		cr(FCS_ID_SIZE, FCS_SIZE_CODE);
		cr(FCS_SEC_ADDR, FCS_SEC_OFF);
		cw(16'h4321, FCS_D_IDOUT);
		`CMP(idMode, 1'b0)
		cmd(FCS_D_IDIN);
		`CMP(idMode, 1'b1)
		cmd(FCS_D_IDOUT);
		`CMP(idMode, 1'b0)
		$display("test ident done");
		cr(16'h1234, 8'h26);
		rw(4'h0, 8'h38);
		cr(16'h7000, 8'h70);
		@(posedge clk) serialMode <= 1'b1;
		cr(16'h9000, 8'h90);
		cr(16'h7800, 8'hB0);
		rw(4'h0, 8'h30);
		cr(16'hF000, 8'h70);
		cr(16'h9001, 8'h11);
		@(posedge clk) serialMode <= 1'b0;
		$display("test map done");
		@(posedge clk) parallelMode <= 1'b1;
		ers(16'h7123, FCS_D_SECT);
		`CMP(busy, 1'b0)
		@(posedge clk) parallelMode <= 1'b0;
		ers(16'h7123, FCS_D_SECT);
		`CMP(busy, 1'b1)
		idle(51);
		$display("test sector done");
		cmd(FCS_D_SECP);
		cw(FCS_SEC_ADDR, FCS_D_SECV);
		`CMP(busy, 1'b1)
		idle(1601);
		rr(4'h1, 8'h04);
		cmd(FCS_D_IDIN);
		cr(FCS_SEC_ADDR, FCS_SEC_ON);
		cw(16'h0000, FCS_D_IDOUT);
		$display("test secure done");
		ers(16'h0555, FCS_D_CHIP);
		`CMP(busy, 1'b1)
		cr(16'h1234, 8'h40);
		cr(16'h1234, 8'h00);
		idle(51);
		cr(16'h1234, 8'hFF);
		rr(4'h1, 8'h00);
		cmd(FCS_D_PROG);
		cw(16'h1234, 8'h3F);
		`CMP(busy, 1'b1)
		idle(1601);
		$display("test chip done");
		cw(16'h0555, FCS_D_AA);
		cw(16'h0AAA, 8'h11);
		cw(16'h0555, FCS_D_PROG);
		cw(16'h2000, 8'h00);
		`CMP(busy, 1'b0)
		rw(4'h0, 8'hC0);
		$display("test refuse done");
		close_out();
	end
endmodule
